// ===== design/lw_log_write.sv
// Log page write command handler with AXI4-Lite register access
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module lw_log_write
   import lw_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // AXI4-Lite write address
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   // AXI4-Lite write data
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // AXI4-Lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic      [1:0]  bresp,
   // AXI4-Lite read address
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   // AXI4-Lite read data
   output logic             rvalid,
   input  wire logic        rready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   // Host interrupt request
   output logic             intrq
);
   logic                awHeld;
   logic                wHeld;
   logic [7:0]          awAddr;
   logic [31:0]         wData;
   logic [3:0]          wStrb;
   logic                doWrite;
   logic                doRead;
   logic [15:0]         secCount;
   logic [7:0]          logAddr;
   logic [15:0]         startSec;
   logic [7:0]          cmdReg;
   logic                featEn;
   logic [STORE_AW-1:0] peekAddr;
   logic [7:0]          errorReg;
   logic [7:0]          statusReg;
   logic [15:0]         remaining;
   logic [15:0]         sectorIdx;
   logic [WORD_IDX_W-1:0] wordIdx;
   lw_state_type        state;
   logic                cmdWrite;
   logic                dataWrite;
   logic                dirWrite;
   logic                blockDone;
   logic                abortNow;
   logic [DIR_DW-1:0]   dirEntry;
   logic [31:0]         peekData;
   logic [16:0]         endSector;
   logic [31:0]         readValue;
   logic                readHit;
   logic                writeHit;

   // Byte-lane merge of a write into a register of up to 32 bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] addr);
      return (addr[1:0] == 2'b00) && (addr <= OFF_PEEK_DATA);
   endfunction : mapped

   // Bus slave: address and data are taken in either order, answered together
   assign awready = ce & ~awHeld;
   assign wready  = ce & ~wHeld;
   assign arready = ce & ~rvalid;
   assign doWrite = ce & awHeld & wHeld & ~bvalid;
   assign doRead  = arvalid & arready;
   assign writeHit = mapped(awAddr);
   assign readHit  = mapped(araddr);

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= 8'h00;
         wData  <= 32'h0000_0000;
         wStrb  <= 4'h0;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            awHeld <= 1'b1;
            awAddr <= awaddr;
         end
         else if (doWrite)
         begin
            awHeld <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wHeld <= 1'b1;
            wData <= wdata;
            wStrb <= wstrb;
         end
         else if (doWrite)
         begin
            wHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (doWrite)
         begin
            bvalid <= 1'b1;
            bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   // Command block registers other than the feature bit are frozen while the command runs, as a host expects
   assign cmdWrite  = doWrite && writeHit && (awAddr == OFF_COMMAND) && (state == IDLE) && wStrb[0];
   // A data word is one whole 32-bit write; partial words are dropped
   assign dataWrite = doWrite && writeHit && (awAddr == OFF_DATA) && (state == XFER) && (wStrb == 4'hf);
   assign dirWrite  = doWrite && writeHit && (awAddr == OFF_DIRECTORY) && (wStrb == 4'hf);
   assign blockDone = dataWrite && (wordIdx == WORD_IDX_W'(WORDS_PER_SECTOR - 1));

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         secCount <= 16'h0000;
         logAddr  <= 8'h00;
         startSec <= 16'h0000;
         featEn   <= 1'b0;
         peekAddr <= '0;
      end
      else if (doWrite && writeHit)
      begin
         if (state == IDLE)
         begin
            case (awAddr)
               OFF_SEC_COUNT: secCount <= 16'(merge({16'h0000, secCount}, wData, wStrb));
               OFF_LOG_ADDR:  logAddr  <= 8'(merge({24'h000000, logAddr}, wData, wStrb));
               OFF_START_SEC: startSec <= 16'(merge({16'h0000, startSec}, wData, wStrb));
               default:       ;
            endcase
         end
         if (awAddr == OFF_FEATURE && wStrb[0])
         begin
            featEn <= wData[0];
         end
         if (awAddr == OFF_PEEK_ADDR)
         begin
            peekAddr <= STORE_AW'(merge({{(32 - STORE_AW){1'b0}}, peekAddr}, wData, wStrb));
         end
      end
   end

   // Directory entry of the selected log: bit 15 read-only, bits 14:0 size in sectors
   lw_mem #(.AW(DIR_AW), .DW(DIR_DW)) dirMem (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .we       (dirWrite),
      .waddr    (wData[DIR_LOG_LSB +: DIR_AW]),
      .wdata    (wData[DIR_DW-1:0]),
      .raddr    (logAddr),
      .rdata    (dirEntry)
   );

   lw_mem #(.AW(STORE_AW), .DW(32)) logStore (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .we       (dataWrite),
      .waddr    ({logAddr[STORE_LOG_W-1:0], sectorIdx[STORE_SEC_W-1:0], wordIdx}),
      .wdata    (wData),
      .raddr    (peekAddr),
      .rdata    (peekData)
   );

   // Start plus count must stay inside the log; 17 bits keep the carry
   assign endSector = {1'b0, startSec} + {1'b0, secCount};
   assign abortNow  = (secCount == 16'h0000)
                    || ({1'b0, secCount} > {2'b00, dirEntry[14:0]})
                    || dirEntry[DIR_RO_BIT] || (logAddr == DIRECTORY_LOG)
                    || (dirEntry[14:0] == 15'h0000) || (!featEn && logAddr < HOST_LOG_BASE)
                    || (endSector > {2'b00, dirEntry[14:0]});

   // Command sequencer; directory read needs one cycle, hence the check state
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state     <= IDLE;
         cmdReg    <= 8'h00;
         statusReg <= STATUS_RESET;
         errorReg  <= ERROR_RESET;
         remaining <= 16'h0000;
         sectorIdx <= 16'h0000;
         wordIdx   <= '0;
      end
      else if (ce)
      begin
         case (state)
            IDLE:
            begin
               if (cmdWrite)
               begin
                  cmdReg <= wData[7:0];
                  if (wData[7:0] == CMD_WRITE_LOG)
                  begin
                     state     <= CHECK;
                     statusReg <= STATUS_BUSY;
                  end
                  else
                  begin
                     statusReg <= STATUS_FAIL;
                     errorReg  <= ERROR_ABORT;
                  end
               end
            end
            CHECK:
            begin
               if (abortNow)
               begin
                  state     <= IDLE;
                  statusReg <= STATUS_FAIL;
                  errorReg  <= ERROR_ABORT;
               end
               else
               begin
                  state     <= XFER;
                  statusReg <= STATUS_DRQ;
                  errorReg  <= ERROR_RESET;
                  remaining <= secCount;
                  sectorIdx <= startSec;
                  wordIdx   <= '0;
               end
            end
            XFER:
            begin
               if (dataWrite)
               begin
                  wordIdx <= wordIdx + 1'b1;
               end
               if (blockDone)
               begin
                  remaining <= remaining - 16'h0001;
                  sectorIdx <= sectorIdx + 16'h0001;
                  if (remaining == 16'h0001)
                  begin
                     state     <= IDLE;
                     statusReg <= STATUS_RESET;
                  end
               end
            end
            default:
            begin
               state <= IDLE;
            end
         endcase
      end
   end

   // Interrupt per finished block or aborted command; a status read clears it, a new event wins
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         intrq <= 1'b0;
      end
      else if (ce)
      begin
         if (blockDone || (state == CHECK && abortNow) || (cmdWrite && wData[7:0] != CMD_WRITE_LOG))
         begin
            intrq <= 1'b1;
         end
         else if (doRead && araddr == OFF_STATUS)
         begin
            intrq <= 1'b0;
         end
      end
   end

   always_comb
   begin
      readValue = 32'h0000_0000;
      case (araddr)
         OFF_SEC_COUNT: readValue = {16'h0000, secCount};
         OFF_LOG_ADDR:  readValue = {24'h000000, logAddr};
         OFF_START_SEC: readValue = {16'h0000, startSec};
         OFF_COMMAND:   readValue = {24'h000000, cmdReg};
         OFF_ERROR:     readValue = {24'h000000, errorReg};
         OFF_STATUS:    readValue = {24'h000000, statusReg};
         OFF_FEATURE:   readValue = {31'h0000_0000, featEn};
         OFF_REMAINING: readValue = {16'h0000, remaining};
         OFF_PEEK_ADDR: readValue = {{(32 - STORE_AW){1'b0}}, peekAddr};
         OFF_PEEK_DATA: readValue = peekData;
         default:       readValue = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (doRead)
         begin
            rvalid <= 1'b1;
            rdata  <= readValue;
            rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rready)
         begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : lw_log_write
`default_nettype wire

// ===== design/lw_mem.sv
// Single-port-write, registered-read memory
`default_nettype none
module lw_mem
   import lw_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 16
)
(
   // Clock, reset, enable
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          ce,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] store [0:(1 << AW)-1];

   always_ff @(posedge core_clk)
   begin
      if (ce && we)
      begin
         store[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata <= '0;
      end
      else if (ce)
      begin
         rdata <= store[raddr];
      end
   end
endmodule : lw_mem
`default_nettype wire

// ===== inc/lw_pkg.sv
// Constants, register map and state type of the log page write command handler
`default_nettype none
package lw_pkg;
   // Command decode
   localparam logic [7:0] CMD_WRITE_LOG    = 8'h3f;
   localparam int         SECTOR_BYTES     = 512;
   localparam int         WORD_BYTES       = 4;
   localparam int         WORDS_PER_SECTOR = SECTOR_BYTES / WORD_BYTES;
   localparam int         WORD_IDX_W       = $clog2(WORDS_PER_SECTOR);
   // Storage geometry: 8 logs of 8 sectors each are kept
   localparam int         STORE_LOG_W      = 3;
   localparam int         STORE_SEC_W      = 3;
   localparam int         STORE_AW         = STORE_LOG_W + STORE_SEC_W + WORD_IDX_W;
   localparam int         DIR_AW           = 8;
   localparam int         DIR_DW           = 16;
   // Register byte offsets
   localparam logic [7:0] OFF_SEC_COUNT    = 8'h00;
   localparam logic [7:0] OFF_LOG_ADDR     = 8'h04;
   localparam logic [7:0] OFF_START_SEC    = 8'h08;
   localparam logic [7:0] OFF_COMMAND      = 8'h0c;
   localparam logic [7:0] OFF_DATA         = 8'h10;
   localparam logic [7:0] OFF_ERROR        = 8'h14;
   localparam logic [7:0] OFF_STATUS       = 8'h18;
   localparam logic [7:0] OFF_FEATURE      = 8'h1c;
   localparam logic [7:0] OFF_DIRECTORY    = 8'h20;
   localparam logic [7:0] OFF_REMAINING    = 8'h24;
   localparam logic [7:0] OFF_PEEK_ADDR    = 8'h28;
   localparam logic [7:0] OFF_PEEK_DATA    = 8'h2c;
   // Field positions
   localparam int         ST_BSY           = 7;
   localparam int         ST_RDY           = 6;
   localparam int         ST_DSC           = 4;
   localparam int         ST_DRQ           = 3;
   localparam int         ST_ERR           = 0;
   localparam int         ER_ABT           = 2;
   localparam int         DIR_RO_BIT       = 15;
   localparam int         DIR_LOG_LSB      = 16;
   // Values after reset and fixed status patterns
   localparam logic [7:0] STATUS_RESET     = 8'h50;
   localparam logic [7:0] ERROR_RESET      = 8'h00;
   localparam logic [7:0] STATUS_BUSY      = 8'h90;
   localparam logic [7:0] STATUS_DRQ       = 8'h58;
   localparam logic [7:0] STATUS_FAIL      = 8'h51;
   localparam logic [7:0] ERROR_ABORT      = 8'h04;
   // Log address classes
   localparam logic [7:0] DIRECTORY_LOG    = 8'h00;
   localparam logic [7:0] HOST_LOG_BASE    = 8'h80;
   // AXI responses
   localparam logic [1:0] RESP_OKAY        = 2'b00;
   localparam logic [1:0] RESP_SLVERR      = 2'b10;

   typedef enum logic [1:0] {IDLE, CHECK, XFER} lw_state_type;
endpackage : lw_pkg
`default_nettype wire

// ===== verification/lw_host.sv
// Host controller model driving the handler's register bus
`default_nettype none
module lw_host
   import lw_pkg::*;
(
   // Clock
   input  wire logic        core_clk,
   // Write channels
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [7:0]  awaddr,
   output var  logic        wvalid,
   input  wire logic        wready,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   input  wire logic        bvalid,
   output var  logic        bready,
   input  wire logic [1:0]  bresp,
   // Read channels
   output var  logic        arvalid,
   input  wire logic        arready,
   output var  logic [7:0]  araddr,
   input  wire logic        rvalid,
   output var  logic        rready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp
);
   initial {awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr, rready} = '0;
   // Handshakes are sampled at the falling edge, where they have settled
   // Response ready rises only once the answer stands, so the slave must hold it a cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic ta, tw, v, b;
      {ta, tw, v, b} = 4'h0;
      @(posedge core_clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s;
      while (!b)
      begin
         @(negedge core_clk);
         ta = ta | (awvalid & awready);
         tw = tw | (wvalid & wready);
         v = bvalid;
         b = bvalid & bready;
         r = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (v && !b) bready <= 1'b1;
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, v, b;
      {ta, v, b} = 3'b000;
      @(posedge core_clk);
      arvalid <= 1'b1; araddr <= a;
      while (!b)
      begin
         @(negedge core_clk);
         ta = ta | (arvalid & arready);
         v = rvalid;
         b = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
         if (v && !b) rready <= 1'b1;
      end
      rready <= 1'b0;
   endtask : rd
   task automatic issue(input int c, input int l, input int s, input logic [7:0] op);
      logic [1:0] r;
      wr(OFF_SEC_COUNT, {16'h0, c[15:0]}, 4'hf, r);
      wr(OFF_LOG_ADDR, {24'h0, l[7:0]}, 4'hf, r);
      wr(OFF_START_SEC, {16'h0, s[15:0]}, 4'hf, r);
      wr(OFF_COMMAND, {24'h0, op}, 4'hf, r);
   endtask : issue
endmodule : lw_host
`default_nettype wire

// ===== verification/lw_log_write_props.sv
// Bus and interrupt checks for the log write handler
`default_nettype none
module lw_log_write_props
   import lw_pkg::*;
(
   // Clock and control
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        ce,
   // Register bus and interrupt
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [7:0]  awaddr,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        intrq
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   read_block_a: assert property (rvalid |-> !arready)
      else $error("read address taken while busy");
   write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   read_resp_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   bad_read_a: assert property (arvalid && arready && araddr > 8'h2c |=> rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   bad_write_a: assert property (awvalid && awready && wvalid && wready && awaddr > 8'h2c |-> ##2 bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   write_block_a: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready)
      else $error("second write taken while pending");
   irq_cause_a: assert property ($rose(intrq) |-> bvalid || $past(bvalid))
      else $error("interrupt without a host write");
   reset_idle_a: assert property ($fell(rst) |-> !intrq && !bvalid && !rvalid)
      else $error("outputs busy after reset");
   cover property ($rose(intrq));
   cover property (bvalid && bresp == RESP_SLVERR);
   cover property (rvalid && rready);
endmodule : lw_log_write_props
bind lw_log_write lw_log_write_props chk (.core_clk(core_clk), .rst(rst), .ce(ce), .awvalid(awvalid),
   .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
   .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .intrq(intrq));
`default_nettype wire

// ===== verification/lw_log_write_test.sv
// Self-checking bench for the log write handler
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nMismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module lw_log_write_test
   import lw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, intrq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   int          nMismatch = 0, samplesChecked = 0, dirSize[int];
   bit          dirRo[int], feat = 0;
   logic [31:0] seed = 32'h0001_1af0, store[int];
   int          cs[6][3] = '{'{5, 128, 0}, '{2, 129, 0}, '{1, 5, 0}, '{0, 128, 0}, '{2, 128, 3}, '{1, 0, 0}};
   always #25 core_clk = ~core_clk;
   lw_log_write DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .intrq(intrq));
   lw_host host (.core_clk(core_clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic bit aborts(int c, int l, int s);
      return c == 0 || c > dirSize[l] || s + c > dirSize[l] || dirRo[l] || l == 0 || (l < 128 && !feat);
   endfunction : aborts
   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      host.rd(a, rv, rs);
      `CHK(nm, e, rv)
   endtask : rdChk
   task automatic dir(input int l, input int sz, input bit ro);
      dirSize[l] = sz;
      dirRo[l] = ro;
      host.wr(OFF_DIRECTORY, {8'h0, l[7:0], ro, sz[14:0]}, 4'hf, rs);
   endtask : dir
   // The interrupt is only looked at after a falling edge, once the launching edge has settled
   task automatic run(input int c, input int l, input int s);
      logic [31:0] d;
      host.issue(c, l, s, CMD_WRITE_LOG);
      @(negedge core_clk);
      if (aborts(c, l, s))
      begin
         `CHK("irq", 1'b1, intrq)
         rdChk("status", OFF_STATUS, {24'h0, STATUS_FAIL});
         rdChk("error", OFF_ERROR, {24'h0, ERROR_ABORT});
         return;
      end
      rdChk("status", OFF_STATUS, {24'h0, STATUS_DRQ});
      for (int k = 0; k < c; k++)
      begin
         for (int w = 0; w < WORDS_PER_SECTOR; w++)
         begin
            d = rnd();
            store[((l % 8) * 8 + (s + k) % 8) * WORDS_PER_SECTOR + w] = d;
            host.wr(OFF_DATA, d, 4'hf, rs);
            @(negedge core_clk);
            if (w == WORDS_PER_SECTOR - 2) `CHK("irq", 1'b0, intrq)
         end
         `CHK("irq", 1'b1, intrq)
         rdChk("status", OFF_STATUS, {24'h0, (k == c - 1) ? STATUS_RESET : STATUS_DRQ});
         rdChk("remaining", OFF_REMAINING, c - k - 1);
      end
      rdChk("error", OFF_ERROR, {24'h0, ERROR_RESET});
   endtask : run
   task testDone;
      $display("Checks %0d, mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : testDone
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rdChk("status", OFF_STATUS, {24'h0, STATUS_RESET});
      rdChk("error", OFF_ERROR, {24'h0, ERROR_RESET});
      rdChk("unmapped", 8'h30, 32'h0);
      `CHK("rresp", RESP_SLVERR, rs)
      host.wr(8'h30, 32'h1, 4'hf, rs);
      `CHK("bresp", RESP_SLVERR, rs)
      host.wr(OFF_FEATURE, 32'h0, 4'hf, rs);
      dir(0, 1, 0);
      dir(128, 4, 0);
      dir(129, 2, 1);
      dir(5, 2, 0);
      foreach (cs[i]) run(cs[i][0], cs[i][1], cs[i][2]);
      host.issue(1, 128, 0, 8'h2f);
      @(negedge core_clk);
      `CHK("irq", 1'b1, intrq)
      rdChk("status", OFF_STATUS, {24'h0, STATUS_FAIL});
      run(2, 128, 1);
      feat = 1;
      host.wr(OFF_FEATURE, 32'h1, 4'hf, rs);
      run(1, 5, 1);
      foreach (store[i])
      begin
         host.wr(OFF_PEEK_ADDR, i, 4'hf, rs);
         rdChk("store", OFF_PEEK_DATA, store[i]);
      end
      testDone();
   end
   // Whole run needs well under ten thousand cycles
   initial
   begin
      #(50 * 40000);
      nMismatch++;
      testDone();
   end
endmodule : lw_log_write_test
`default_nettype wire
